// *** rtl/msc_sync_control.sv ***
// Multi-chip sync control: registers, edge capture, phase averaging, offset strobe and interrupt.
//
// Contract
// RQ1: Bit 7 enables sync logic, resets zero.
// RQ2: Bit 6 selects FIFO-reset or data rate.
// RQ3: Bit 3 selects rising or falling sync edge.
// RQ4: Average two-to-the-n phase samples, code resets zero.
// RQ5: Six-bit phase offset in conversion clock cycles.
// RQ6: Output strobe shifted by requested phase offset.
// RQ7: Averaged phase readback 6.2; mismatch flags error.
// RQ8: Locked flag on sync; lost flag afterwards.
// RQ9: Source gives clean edge after configuration.
`timescale 1ns/1ps
module msc_sync_control #(
    parameter int PHASE_W = 6,
    parameter int AVG_W = 3
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Sync link.
    input wire logic sync_in,
    input wire logic fifo_reset_req,
    // Results.
    output logic align_strobe,
    output logic sync_locked,
    output logic sync_lost,
    output logic [7:0] phase_readback,
    output logic irq
);
    import msc_pkg::*;

    localparam int SUM_W = PHASE_W + (1 << AVG_W) - 1 + 2;

    msc_ctrl_s ctrl_ff;
    logic [PHASE_W-1:0] phase_req_ff;
    logic [IRQ_BITS-1:0] irq_status_ff;
    logic [IRQ_BITS-1:0] irq_mask_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic wr_pend_ff;
    logic [7:0] wr_idx_ff;
    logic sync_d_ff;
    logic fifo_arm_ff;
    logic [PHASE_W-1:0] phase_cnt_ff;
    msc_state_e state_ff;
    logic [SUM_W-1:0] sum_ff;
    logic [8:0] samp_cnt_ff;
    msc_meas_s meas_ff;
    logic locked_ff;
    logic lost_ff;
    logic [PHASE_W-1:0] dly_ff;
    logic dly_run_ff;
    logic align_ff;
    logic irq_ff;

    logic addr_ok;
    logic [7:0] addr_idx;
    logic wr_ctrl;
    logic [31:0] rd_mux;
    logic edge_hit;
    logic take;
    logic [SUM_W-1:0] nxt_sum;
    logic [8:0] nxt_cnt;
    logic [8:0] target;
    logic [7:0] nxt_avg;
    logic finish;
    logic avg_match;
    logic [IRQ_BITS-1:0] irq_ev;
    logic [IRQ_BITS-1:0] irq_clr;
    logic [SUM_W-1:0] scaled;

    // Bus decode; address bits above the word index are ignored.
    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3) && (haddr[1:0] == 2'h0);
    assign addr_idx = haddr[9:2];
    assign wr_ctrl = wr_pend_ff && (wr_idx_ff == IDX_SYNC_CONTROL);

    always_comb begin
        unique case (addr_idx)
            IDX_SYNC_CONTROL: rd_mux = {24'h00_0000, ctrl_ff[7:4] & 4'hC, ctrl_ff[3:0]};
            IDX_SYNC_PHASE_REQUEST: rd_mux = {26'h000_0000, phase_req_ff};
            IDX_SYNC_STATUS: rd_mux = {24'h00_0000, lost_ff, locked_ff, 6'h00};
            IDX_SYNC_PHASE_READBACK: rd_mux = {24'h00_0000, meas_ff.phase};
            IDX_IRQ_STATUS: rd_mux = {28'h000_0000, irq_status_ff};
            IDX_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask_ff};
            default: rd_mux = HRDATA_UNMAPPED;
        endcase
    end

    // Address phase capture; reads are answered with zero wait states.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 8'h00;
            hrdata_ff <= HRDATA_UNMAPPED;
            hreadyout_ff <= 1'b1;
        end else begin
            hreadyout_ff <= 1'b1;
            wr_pend_ff <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_idx_ff <= addr_idx;
                hrdata_ff <= hwrite ? HRDATA_UNMAPPED : rd_mux;
            end
        end
    end

    // Configuration registers, written in the data phase.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_ff <= RST_SYNC_CONTROL; // RQ1 RQ2 RQ3 RQ4
            phase_req_ff <= RST_PHASE_REQUEST; // RQ5
            irq_mask_ff <= RST_IRQ;
        end else if (wr_pend_ff) begin
            if (wr_idx_ff == IDX_SYNC_CONTROL) begin
                ctrl_ff <= msc_ctrl_s'({hwdata[7:6], 2'h0, hwdata[3:0]});
            end
            if (wr_idx_ff == IDX_SYNC_PHASE_REQUEST) begin
                phase_req_ff <= hwdata[PHASE_W-1:0]; // RQ5
            end
            if (wr_idx_ff == IDX_IRQ_MASK) begin
                irq_mask_ff <= hwdata[IRQ_BITS-1:0];
            end
        end
    end

    // Edge capture and the free-running phase counter in conversion clock cycles.
    assign edge_hit = ctrl_ff.rising_edge ? (sync_in && !sync_d_ff) : (!sync_in && sync_d_ff); // RQ3
    assign take = ctrl_ff.enable && edge_hit && (ctrl_ff.data_rate || fifo_arm_ff); // RQ1 RQ2

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync_d_ff <= 1'b0;
            phase_cnt_ff <= '0;
            fifo_arm_ff <= 1'b0;
        end else begin
            sync_d_ff <= sync_in;
            phase_cnt_ff <= phase_cnt_ff + 1'b1;
            // In FIFO-rate mode one edge is accepted per FIFO reset request.
            if (fifo_reset_req && ctrl_ff.enable) begin
                fifo_arm_ff <= 1'b1; // RQ2
            end else if (take || !ctrl_ff.enable) begin
                fifo_arm_ff <= 1'b0;
            end
        end
    end

    // Phase averaging over two to the code samples, result in 6.2 format.
    assign target = 9'(1 << ctrl_ff.avg_code); // RQ4
    assign nxt_sum = (state_ff == MS_IDLE) ? SUM_W'(phase_cnt_ff) : sum_ff + SUM_W'(phase_cnt_ff);
    assign nxt_cnt = (state_ff == MS_IDLE) ? 9'h001 : samp_cnt_ff + 9'h001;
    assign finish = take && (nxt_cnt >= target); // RQ4
    assign scaled = SUM_W'({nxt_sum, 2'b00} >> ctrl_ff.avg_code);
    assign nxt_avg = scaled[7:0]; // RQ7
    assign avg_match = (nxt_avg == {phase_req_ff, 2'b00}); // RQ7

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !ctrl_ff.enable) begin
            state_ff <= MS_IDLE;
            sum_ff <= '0;
            samp_cnt_ff <= 9'h000;
        end else if (take) begin
            sum_ff <= nxt_sum;
            samp_cnt_ff <= nxt_cnt;
            state_ff <= finish ? MS_IDLE : MS_ACC;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meas_ff <= '{done: 1'b0, match: 1'b0, phase: RST_PHASE_READBACK};
        end else begin
            meas_ff.done <= finish;
            if (finish) begin
                meas_ff.phase <= nxt_avg; // RQ7
                meas_ff.match <= avg_match;
            end
        end
    end

    // Lock tracking; disabling the logic clears both flags.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !ctrl_ff.enable) begin
            locked_ff <= 1'b0;
            lost_ff <= 1'b0;
        end else if (finish) begin
            if (avg_match) begin
                locked_ff <= 1'b1; // RQ8
            end else if (locked_ff) begin
                locked_ff <= 1'b0;
                lost_ff <= 1'b1; // RQ8
            end
        end
    end

    // Offset strobe fires the requested number of cycles plus two after the accepted edge.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dly_ff <= '0;
            dly_run_ff <= 1'b0;
            align_ff <= 1'b0;
        end else begin
            align_ff <= dly_run_ff && (dly_ff == '0); // RQ6
            if (take) begin
                dly_ff <= phase_req_ff; // RQ5 RQ6
                dly_run_ff <= 1'b1;
            end else if (dly_run_ff) begin
                dly_run_ff <= (dly_ff != '0);
                dly_ff <= dly_ff - 1'b1;
            end
        end
    end

    // Sticky interrupt status; a new event wins over a write-one clear in the same cycle.
    assign irq_ev[IRQ_LOCKED] = finish && avg_match && !locked_ff;
    assign irq_ev[IRQ_LOST] = finish && !avg_match && locked_ff;
    assign irq_ev[IRQ_TIMING_ERR] = finish && !avg_match; // RQ7
    assign irq_ev[IRQ_MEAS_DONE] = finish;
    assign irq_clr = (wr_pend_ff && wr_idx_ff == IDX_IRQ_STATUS) ? hwdata[IRQ_BITS-1:0] : RST_IRQ;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_status_ff <= RST_IRQ;
            irq_ff <= 1'b0;
        end else begin
            irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_ev;
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;
    assign align_strobe = align_ff;
    assign sync_locked = locked_ff;
    assign sync_lost = lost_ff;
    assign phase_readback = meas_ff.phase;
    assign irq = irq_ff;

    AST_DISABLE_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ1
        (!ctrl_ff.enable && !wr_ctrl) |=> (state_ff == MS_IDLE) && !locked_ff && !lost_ff && !take)
        else $error("Sync logic active while disabled.");

    AST_FIFO_RATE_GATE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ2
        (!ctrl_ff.data_rate && !fifo_arm_ff) |-> !take)
        else $error("Edge taken in FIFO rate mode without a FIFO reset request.");

    AST_EDGE_POLARITY: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ3
        take |-> (sync_in == ctrl_ff.rising_edge) && ($past(sync_in) != ctrl_ff.rising_edge))
        else $error("Sync taken on the wrong edge.");

    AST_SINGLE_SAMPLE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ4
        (take && ctrl_ff.avg_code == 3'h0) |=> meas_ff.done && (meas_ff.phase == {$past(phase_cnt_ff), 2'b00}))
        else $error("Single-sample average did not complete at once.");

    AST_RESET_VALUES: assert property (@(posedge ref_clk) // RQ5
        sys_rst |=> (phase_req_ff == RST_PHASE_REQUEST) && (ctrl_ff == RST_SYNC_CONTROL))
        else $error("Configuration registers not at reset values.");

    AST_ZERO_OFFSET: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ6
        (take && phase_req_ff == '0) |=> ##1 align_strobe)
        else $error("Zero offset strobe not two edges after the sync edge.");

    AST_TIMING_ERROR: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ7
        (meas_ff.done && meas_ff.phase != {phase_req_ff, 2'b00} && $stable(phase_req_ff)) |-> irq_status_ff[IRQ_TIMING_ERR])
        else $error("Phase mismatch did not flag a timing error.");

    AST_LOCK_LOST: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ8
        (finish && locked_ff && !avg_match && ctrl_ff.enable) |=> sync_lost && !sync_locked)
        else $error("Lost lock not reported.");

    AST_LOCK_SET: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ8
        (meas_ff.done && meas_ff.match && ctrl_ff.enable) |-> sync_locked)
        else $error("Matching measurement did not lock.");

    AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 irq == |($past(irq_status_ff) & $past(irq_mask_ff)))
        else $error("Interrupt output does not follow masked status.");

    AST_FIFO_ARM_USED: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ2
        (take && !ctrl_ff.data_rate && !fifo_reset_req) |=> !fifo_arm_ff)
        else $error("FIFO rate arm not consumed by the accepted edge.");

    AST_FIRST_SAMPLE_PENDING: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ4
        (take && state_ff == MS_IDLE && ctrl_ff.avg_code != 3'h0) |=> !meas_ff.done)
        else $error("Multi-sample average completed on its first sample.");

    AST_ONE_OFFSET: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ6
        (take && phase_req_ff == PHASE_W'(1)) |=> ##2 align_strobe)
        else $error("One-cycle offset strobe not three edges after the sync edge.");

    AST_EVENT_WINS: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ7
        irq_ev[IRQ_TIMING_ERR] |=> irq_status_ff[IRQ_TIMING_ERR])
        else $error("Timing error event lost against a status clear.");

endmodule : msc_sync_control

// *** rtl/msc_pkg.sv ***
// Shared constants, field layouts and types of the multi-chip sync control block.
package msc_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_SYNC_CONTROL = 8'h10;
    localparam logic [7:0] IDX_SYNC_PHASE_REQUEST = 8'h11;
    localparam logic [7:0] IDX_SYNC_STATUS = 8'h12;
    localparam logic [7:0] IDX_SYNC_PHASE_READBACK = 8'h13;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

    // Field positions.
    localparam int BIT_ENABLE = 7;
    localparam int BIT_DATA_RATE = 6;
    localparam int BIT_RISING_EDGE = 3;
    localparam int BIT_LOST = 7;
    localparam int BIT_LOCKED = 6;
    localparam int IRQ_LOCKED = 0;
    localparam int IRQ_LOST = 1;
    localparam int IRQ_TIMING_ERR = 2;
    localparam int IRQ_MEAS_DONE = 3;
    localparam int IRQ_BITS = 4;

    // Reset values.
    localparam logic [7:0] RST_SYNC_CONTROL = 8'h48;
    localparam logic [5:0] RST_PHASE_REQUEST = 6'h00;
    localparam logic [7:0] RST_PHASE_READBACK = 8'h00;
    localparam logic [IRQ_BITS-1:0] RST_IRQ = 4'h0;

    // AHB-Lite codes.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] HRDATA_UNMAPPED = 32'h0000_0000;

    // Layout of the sync control register.
    typedef struct packed {
        logic enable;
        logic data_rate;
        logic [1:0] rsvd;
        logic rising_edge;
        logic [2:0] avg_code;
    } msc_ctrl_s;

    // One completed phase measurement.
    typedef struct packed {
        logic done;
        logic match;
        logic [7:0] phase;
    } msc_meas_s;

    typedef enum logic [1:0] {
        MS_IDLE = 2'b01,
        MS_ACC = 2'b10
    } msc_state_e;

endpackage : msc_pkg

// *** testbench/msc_sync_source.sv ***
// Behavioural model of the external sync pulse source shared by several converters.
`timescale 1ns/1ps
module msc_sync_source (
    // Clock.
    input wire logic ref_clk,
    // Commands from the bench.
    input wire logic fire,
    input wire logic pol,
    // Sync line.
    output logic sync_in
);
    // The line idles at the inverse of the active level, so each fire gives one clean active edge.
    always_ff @(posedge ref_clk) begin
        sync_in <= fire ? pol : ~pol;
    end
endmodule : msc_sync_source

// *** testbench/msc_sync_control_bench.sv ***
// Self-checking bench of the multi-chip sync control block.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module msc_sync_control_bench;
    import msc_pkg::*;
    logic ref_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, fire = 0, pol = 1, fifo_reset_req = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic hreadyout, hresp, sync_in, align_strobe, sync_locked, sync_lost, irq;
    logic [7:0] phase_readback, p;
    int errors = 0, comparisons = 0, cyc = 0;

    msc_sync_control uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sync_in(sync_in),
        .fifo_reset_req(fifo_reset_req), .align_strobe(align_strobe), .sync_locked(sync_locked),
        .sync_lost(sync_lost), .phase_readback(phase_readback), .irq(irq));
    msc_sync_source src (.ref_clk(ref_clk), .fire(fire), .pol(pol), .sync_in(sync_in));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic bus(input logic wr, input logic [1:0] tr, input logic [7:0] idx, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= tr;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        `CHK(hresp, 1'b0)
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, HTRANS_NONSEQ, idx, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, HTRANS_NONSEQ, idx, 32'h0, q);
        `CHK(q, e)
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle

    // Fires one sync edge at a fixed phase of a 64-cycle frame and times the strobe; -1 means none.
    task automatic shoot(input logic [5:0] ph, input int e);
        int n;
        @(posedge ref_clk);
        while (cyc[5:0] !== ph) @(posedge ref_clk);
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        n = 0;
        repeat (80) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (align_strobe === 1'b1) break;
        end
        if (align_strobe !== 1'b1) n = -1;
        `CHK(n, e)
        if (e >= 0) begin
            @(posedge ref_clk);
            #1;
            `CHK(align_strobe, 1'b0)
        end
    endtask : shoot

    task automatic t_reset();
        logic [31:0] q;
        rd(IDX_SYNC_CONTROL, 32'h48);
        rd(IDX_SYNC_PHASE_REQUEST, 32'h0);
        rd(IDX_SYNC_STATUS, 32'h0);
        rd(IDX_SYNC_PHASE_READBACK, 32'h0);
        wr(8'h30, 32'hFF);
        rd(8'h30, 32'h0);
        wr(IDX_SYNC_PHASE_REQUEST, 32'hFFFF_FFFF);
        rd(IDX_SYNC_PHASE_REQUEST, 32'h3F);
        // A sequential transfer type is accepted like a non-sequential one.
        bus(1'b1, 2'h3, IDX_IRQ_MASK, 32'h5, q);
        rd(IDX_IRQ_MASK, 32'h5);
        wr(IDX_IRQ_MASK, 32'h0);
        shoot(6'h0, -1);
    endtask : t_reset

    task automatic t_offset();
        int offs[3] = '{0, 1, 63};
        wr(IDX_SYNC_CONTROL, 32'hC8);
        foreach (offs[i]) begin
            wr(IDX_SYNC_PHASE_REQUEST, 32'(offs[i]));
            shoot(6'h0, offs[i] + 2);
        end
    endtask : t_offset

    task automatic t_average();
        int s;
        wr(IDX_SYNC_PHASE_REQUEST, 32'h0);
        shoot(6'h0, 2);
        p = phase_readback;
        `CHK(p[1:0], 2'h0)
        rd(IDX_SYNC_PHASE_READBACK, {24'h0, p});
        s = p[7:2];
        wr(IDX_SYNC_CONTROL, 32'hC9);
        wr(IDX_IRQ_STATUS, 32'hF);
        shoot(6'h0, 2);
        rd(IDX_IRQ_STATUS, 32'h0);
        shoot(6'h1, 2);
        `CHK(phase_readback, 8'((s + (s + 1) % 64) * 2))
    endtask : t_average

    task automatic t_count(input logic [2:0] code);
        wr(IDX_SYNC_CONTROL, {24'h0, 5'h19, code});
        wr(IDX_IRQ_MASK, 32'h8);
        wr(IDX_IRQ_STATUS, 32'hF);
        repeat ((1 << code) - 1) shoot(6'h0, 2);
        `CHK(irq, 1'b0)
        shoot(6'h0, 2);
        `CHK(irq, 1'b1)
        `CHK(phase_readback, p)
    endtask : t_count

    task automatic t_irq();
        wr(IDX_IRQ_MASK, 32'h0);
        settle();
        `CHK(irq, 1'b0)
        wr(IDX_IRQ_MASK, 32'h8);
        settle();
        `CHK(irq, 1'b1)
        wr(IDX_IRQ_STATUS, 32'h8);
        settle();
        `CHK(irq, 1'b0)
    endtask : t_irq

    task automatic t_lock();
        wr(IDX_SYNC_CONTROL, 32'hC8);
        wr(IDX_SYNC_PHASE_REQUEST, {26'h0, p[7:2]});
        shoot(6'h0, p[7:2] + 2);
        `CHK(sync_locked, 1'b1)
        rd(IDX_SYNC_STATUS, 32'h40);
        rd(IDX_IRQ_STATUS, 32'hD);
        wr(IDX_IRQ_STATUS, 32'hF);
        shoot(6'h5, p[7:2] + 2);
        `CHK(sync_lost, 1'b1)
        `CHK(sync_locked, 1'b0)
        rd(IDX_SYNC_STATUS, 32'h80);
        rd(IDX_IRQ_STATUS, 32'hE);
    endtask : t_lock

    task automatic t_fifo();
        wr(IDX_SYNC_PHASE_REQUEST, 32'h0);
        wr(IDX_SYNC_CONTROL, 32'h88);
        shoot(6'h0, -1);
        fifo_reset_req <= 1'b1;
        @(posedge ref_clk);
        fifo_reset_req <= 1'b0;
        shoot(6'h0, 2);
        shoot(6'h0, -1);
    endtask : t_fifo

    task automatic t_fall();
        wr(IDX_SYNC_CONTROL, 32'hC0);
        pol <= 1'b0;
        shoot(6'h0, 2);
        wr(IDX_SYNC_CONTROL, 32'h0);
        pol <= 1'b1;
        settle();
        `CHK(sync_lost, 1'b0)
    endtask : t_fall

    // Reset in mid-run returns the configuration to its reset values.
    task automatic t_rerst();
        wr(IDX_SYNC_PHASE_REQUEST, 32'h15);
        wr(IDX_SYNC_CONTROL, 32'hCF);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rd(IDX_SYNC_CONTROL, 32'h48);
        rd(IDX_SYNC_PHASE_REQUEST, 32'h0);
        rd(IDX_SYNC_STATUS, 32'h0);
    endtask : t_rerst

    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_offset();
        t_average();
        t_count(3'h3);
        t_count(3'h7);
        t_irq();
        t_lock();
        t_fifo();
        t_fall();
        t_rerst();
        end_sim();
    end
endmodule : msc_sync_control_bench
